// file: rtl/pim_port_input_mux.sv
`timescale 1ns/10ps
`include "pim_map.svh"
module pim_port_input_mux
	import pim_pkg::*;
#(
	parameter int FIFO_AW = `PIM_FIFO_AW
) (
	input  wire logic                      core_clk,
	input  wire logic                      sys_rst,
	input  wire logic                      port_in_ref_clock,
	input  wire pim_mode_e                 mode,
	input  wire logic                      virtual_port_isolate,
	input  wire logic [`PIM_DATA_W-1:0]    port_in_data_bus,
	input  wire logic                      port_in_valid,
	input  wire logic                      port_in_error,
	output logic      [`PIM_PIN_COUNT-1:0] port_in_pulldown_en,
	output logic      [`PIM_PIN_COUNT-1:0] port_in_buffer_en,
	output pim_rx_s                        rx_side,
	output pim_tx_s                        tx_side,
	output logic                           sample_strobe,
	output logic                           overflow_pulse
);

	// mode decoding shared by the pin controls and the link-side gating
	function automatic logic is_phy_role(input pim_mode_e m);
		is_phy_role = (m == PIM_MII_PHY) || (m == PIM_RMII_PHY);
	endfunction : is_phy_role

	function automatic logic buffer_on(input pim_mode_e m, input logic iso);
		if (m == PIM_INT_PHY)
			buffer_on = 1'b0;
		else if (is_phy_role(m) && iso)
			buffer_on = 1'b0;
		else
			buffer_on = 1'b1;
	endfunction : buffer_on

	function automatic logic pulldown_on(input pim_mode_e m, input logic iso);
		pulldown_on = !(is_phy_role(m) && iso);
	endfunction : pulldown_on

	function automatic logic error_used(input pim_mode_e m);
		error_used = (m != PIM_RMII_PHY) && (m != PIM_INT_PHY);
	endfunction : error_used

	// link domain
	logic        link_rst;
	pim_cfg_s    core_cfg;
	pim_cfg_s    link_cfg;
	pim_sample_s pin_sample;
	pim_sample_s gated;
	pim_sample_s next_gated;
	logic        prev_active;
	logic        push;
	logic        fifo_full;
	logic        ovf_toggle;

	assign core_cfg.mode    = mode;
	assign core_cfg.isolate = virtual_port_isolate;

	// reset reaches the link side by its own synchroniser; no reset on it
	pim_sync3 #(.W(1)) u_rst_sync (
		.clk (port_in_ref_clock),
		.rst (`PIM_SYNC_RESET),
		.d   (sys_rst),
		.q   (link_rst)
	);

	pim_sync3 #(.W($bits(pim_cfg_s))) u_cfg_sync (
		.clk (port_in_ref_clock),
		.rst (link_rst),
		.d   (core_cfg),
		.q   (link_cfg)
	);

	// pins are launched on this same reference clock, so one register suffices
	always_ff @(posedge port_in_ref_clock)
	begin
		if (link_rst)
			pin_sample <= '0;
		else
		begin
			pin_sample.data  <= port_in_data_bus;
			pin_sample.valid <= port_in_valid;
			pin_sample.error <= port_in_error;
		end
	end

	always_comb
	begin
		next_gated = pin_sample;
		if (link_cfg.mode == PIM_RMII_MAC || link_cfg.mode == PIM_RMII_PHY)
			next_gated.data[`PIM_DATA_W-1:`PIM_RMII_DATA_W] = '0;
		if (!error_used(link_cfg.mode))
			next_gated.error = 1'b0;
		if (!buffer_on(link_cfg.mode, link_cfg.isolate))
			next_gated = '0;
	end

	always_ff @(posedge port_in_ref_clock)
	begin
		if (link_rst)
		begin
			gated       <= '0;
			prev_active <= 1'b0;
		end
		else
		begin
			gated       <= next_gated;
			// one sample behind gated, so the closing idle still pushes
			prev_active <= gated.valid | gated.error;
		end
	end

	// idle samples are dropped, but the first idle after activity is kept
	// so the far side sees the frame close
	assign push = gated.valid | gated.error | prev_active;

	always_ff @(posedge port_in_ref_clock)
	begin
		if (link_rst)
			ovf_toggle <= 1'b0;
		else if (push && fifo_full)
			ovf_toggle <= ~ovf_toggle;
	end

	// core domain
	pim_sample_s popped;
	logic        fifo_empty;
	logic        pop_done;
	logic        ovf_sync;
	logic        ovf_seen;
	pim_rx_s     next_rx;
	pim_tx_s     next_tx;

	pim_cdc_fifo #(.W($bits(pim_sample_s)), .AW(FIFO_AW)) u_fifo (
		.wclk  (port_in_ref_clock),
		.wrst  (link_rst),
		.wr_en (push),
		.wdata (gated),
		.full  (fifo_full),
		.rclk  (core_clk),
		.rrst  (sys_rst),
		.rd_en (1'b1),
		.rdata (popped),
		.empty (fifo_empty)
	);

	pim_sync3 #(.W(1)) u_ovf_sync (
		.clk (core_clk),
		.rst (sys_rst),
		.d   (ovf_toggle),
		.q   (ovf_sync)
	);

	always_ff @(posedge core_clk)
	begin
		if (sys_rst)
		begin
			pop_done       <= 1'b0;
			ovf_seen       <= 1'b0;
			overflow_pulse <= 1'b0;
			sample_strobe  <= 1'b0;
		end
		else
		begin
			pop_done       <= !fifo_empty;
			ovf_seen       <= ovf_sync;
			overflow_pulse <= ovf_sync ^ ovf_seen;
			sample_strobe  <= pop_done;
		end
	end

	genvar pin;
	generate
		for (pin = 0; pin < `PIM_PIN_COUNT; pin = pin + 1)
		begin : g_pin_ctrl
			always_ff @(posedge core_clk)
			begin
				if (sys_rst)
				begin
					port_in_pulldown_en[pin] <= 1'b1;
					port_in_buffer_en[pin]   <= 1'b0;
				end
				else
				begin
					port_in_pulldown_en[pin] <= pulldown_on(mode, virtual_port_isolate);
					port_in_buffer_en[pin]   <= buffer_on(mode, virtual_port_isolate);
				end
			end
		end
	endgenerate

	always_comb
	begin
		next_rx = '0;
		case (mode)
			PIM_MII_MAC:
			begin
				next_rx.data = popped.data;
				next_rx.dv   = popped.valid;
				next_rx.er   = popped.error & popped.valid;
				next_rx.lpi  = popped.error & !popped.valid
					& (popped.data == `PIM_LPI_CODE);
			end
			PIM_RMII_MAC:
			begin
				next_rx.data   = popped.data;
				next_rx.crs_dv = popped.valid;
				next_rx.er     = popped.error;
			end
			default:
				next_rx = '0;
		endcase
	end

	always_comb
	begin
		next_tx = '0;
		case (mode)
			PIM_MII_PHY:
			begin
				next_tx.en    = popped.valid;
				next_tx.data  = popped.valid ? popped.data : '0;
				next_tx.abort = popped.error & popped.valid;
			end
			PIM_RMII_PHY:
			begin
				next_tx.en   = popped.valid;
				next_tx.data = popped.valid ? popped.data : '0;
			end
			default:
				next_tx = '0;
		endcase
	end

	always_ff @(posedge core_clk)
	begin
		if (sys_rst)
			rx_side <= '0;
		else if (pop_done)
			rx_side <= next_rx;
	end

	always_ff @(posedge core_clk)
	begin
		if (sys_rst)
			tx_side <= '0;
		else if (pop_done)
			tx_side <= next_tx;
	end

endmodule : pim_port_input_mux

// file: rtl/pim_map.svh
// What this block does
// - MAC role, MII or RMII: data bit 0 is receive data from the PHY
// - PHY role, MII or RMII: data bit 0 is transmit data from the MAC
// - PHY role with isolate set: pull-downs and input buffers switched off
// - MII MAC role: valid is RX_DV, qualifying error as RX_ER; the four data bits pass ungated
// - MII PHY role: valid is TX_EN; data and error count only while high
// - RMII MAC role: valid is the combined CRS_DV from the PHY
// - RMII PHY role: valid is TX_EN; only data bits one and zero count
// - MII MAC role: error is RX_ER, packet error or Low Power Idle
// - MII PHY role: error is TX_ER, abort the packet in progress
// - RMII MAC role: error is RX_ER, receive error in current packet
// - RMII PHY role: error input ignored completely
// - internal PHY mode: all three inputs ignored, only pull-downs stay
// - MII modes: inputs sampled on the port input reference clock
`ifndef PIM_MAP_SVH
`define PIM_MAP_SVH

`define PIM_DATA_W      4
`define PIM_RMII_DATA_W 2
`define PIM_FIFO_AW     3
`define PIM_LPI_CODE    4'h1
`define PIM_PIN_DATA0   0
`define PIM_PIN_VALID   1
`define PIM_PIN_ERROR   2
`define PIM_PIN_COUNT   3
`define PIM_SYNC_RESET  1'b0

`endif

// file: rtl/pim_pkg.sv
package pim_pkg;

	typedef enum logic [2:0] {
		PIM_MII_MAC,
		PIM_MII_PHY,
		PIM_RMII_MAC,
		PIM_RMII_PHY,
		PIM_INT_PHY
	} pim_mode_e;

	typedef struct packed {
		logic [3:0] data;
		logic       valid;
		logic       error;
	} pim_sample_s;

	typedef struct packed {
		logic [3:0] data;
		logic       dv;
		logic       crs_dv;
		logic       er;
		logic       lpi;
	} pim_rx_s;

	typedef struct packed {
		logic [3:0] data;
		logic       en;
		logic       abort;
	} pim_tx_s;

	typedef struct packed {
		pim_mode_e mode;
		logic      isolate;
	} pim_cfg_s;

endpackage : pim_pkg

// file: rtl/pim_sync3.sv
`timescale 1ns/10ps
// three-stage synchroniser; output moves only once stages two and three agree
module pim_sync3 #(
	parameter int W = 1
) (
	input  wire logic         clk,
	input  wire logic         rst,
	input  wire logic [W-1:0] d,
	output logic      [W-1:0] q
);
	logic [W-1:0] stage1;
	logic [W-1:0] stage2;
	logic [W-1:0] stage3;

	always_ff @(posedge clk)
	begin
		stage1 <= d;
		stage2 <= stage1;
		stage3 <= stage2;
	end

	always_ff @(posedge clk)
	begin
		if (rst)
			q <= '0;
		else if (stage2 == stage3)
			q <= stage3;
	end
endmodule : pim_sync3

// file: rtl/pim_cdc_fifo.sv
`timescale 1ns/10ps
// dual-clock sample store with gray pointers; read data come from a register
module pim_cdc_fifo #(
	parameter int W  = 6,
	parameter int AW = 3
) (
	input  wire logic         wclk,
	input  wire logic         wrst,
	input  wire logic         wr_en,
	input  wire logic [W-1:0] wdata,
	output logic              full,
	input  wire logic         rclk,
	input  wire logic         rrst,
	input  wire logic         rd_en,
	output logic      [W-1:0] rdata,
	output logic              empty
);
	logic [W-1:0] mem [0:(1<<AW)-1];
	logic [AW:0]  wbin;
	logic [AW:0]  rbin;
	logic [AW:0]  wgray;
	logic [AW:0]  rgray;
	logic [AW:0]  wgray_r;
	logic [AW:0]  rgray_w;
	logic [AW:0]  next_wbin;
	logic [AW:0]  next_rbin;

	assign next_wbin = wbin + (AW+1)'(1);
	assign next_rbin = rbin + (AW+1)'(1);
	assign full      = (wgray == {~rgray_w[AW:AW-1], rgray_w[AW-2:0]});
	assign empty     = (rgray == wgray_r);

	always_ff @(posedge wclk)
	begin
		if (wr_en && !full)
			mem[wbin[AW-1:0]] <= wdata;
	end

	always_ff @(posedge wclk)
	begin
		if (wrst)
		begin
			wbin  <= '0;
			wgray <= '0;
		end
		else if (wr_en && !full)
		begin
			wbin  <= next_wbin;
			wgray <= next_wbin ^ (next_wbin >> 1);
		end
	end

	always_ff @(posedge rclk)
	begin
		if (rrst)
		begin
			rbin  <= '0;
			rgray <= '0;
			rdata <= '0;
		end
		else if (rd_en && !empty)
		begin
			rdata <= mem[rbin[AW-1:0]];
			rbin  <= next_rbin;
			rgray <= next_rbin ^ (next_rbin >> 1);
		end
	end

	pim_sync3 #(.W(AW+1)) u_wptr_sync (
		.clk (rclk),
		.rst (rrst),
		.d   (wgray),
		.q   (wgray_r)
	);

	pim_sync3 #(.W(AW+1)) u_rptr_sync (
		.clk (wclk),
		.rst (wrst),
		.d   (rgray),
		.q   (rgray_w)
	);
endmodule : pim_cdc_fifo

// file: tb/pim_port_input_mux_sva.sv
`timescale 1ns/10ps
module pim_port_input_mux_sva
	import pim_pkg::*;
(
	input wire logic       core_clk,
	input wire logic       sys_rst,
	input wire pim_mode_e  mode,
	input wire logic       virtual_port_isolate,
	input wire logic [2:0] port_in_pulldown_en,
	input wire logic [2:0] port_in_buffer_en,
	input wire pim_rx_s    rx_side,
	input wire pim_tx_s    tx_side,
	input wire logic       sample_strobe
);
	default clocking @(posedge core_clk); endclocking
	default disable iff (sys_rst);
	wire phy = mode == PIM_MII_PHY || mode == PIM_RMII_PHY;
	wire st  = sample_strobe;
	property p_iso;
		phy && virtual_port_isolate |=> port_in_pulldown_en == 3'h0 && port_in_buffer_en == 3'h0;
	endproperty
	a_iso: assert property (p_iso) else $error("pins not off on isolate");
	property p_int;
		mode == PIM_INT_PHY |=> port_in_pulldown_en == 3'h7 && port_in_buffer_en == 3'h0;
	endproperty
	a_int: assert property (p_int) else $error("internal mode pins wrong");
	property p_live;
		mode != PIM_INT_PHY && !(phy && virtual_port_isolate) |=> port_in_buffer_en == 3'h7;
	endproperty
	a_live: assert property (p_live) else $error("input buffers off");
	property p_dvq;
		st && mode == PIM_MII_MAC && rx_side.er |-> rx_side.dv;
	endproperty
	a_dvq: assert property (p_dvq) else $error("error without valid");
	property p_gate;
		st && mode == PIM_MII_PHY && !tx_side.en |-> tx_side.data == 4'h0 && !tx_side.abort;
	endproperty
	a_gate: assert property (p_gate) else $error("ungated transmit sample");
	property p_crs;
		st && mode == PIM_RMII_MAC |-> rx_side.data[3:2] == 2'h0 && !rx_side.lpi;
	endproperty
	a_crs: assert property (p_crs) else $error("reduced receive width");
	property p_rphy;
		st && mode == PIM_RMII_PHY |-> tx_side.data[3:2] == 2'h0 && !tx_side.abort;
	endproperty
	a_rphy: assert property (p_rphy) else $error("reduced transmit sample");
	property p_lpi;
		st && rx_side.lpi |-> mode == PIM_MII_MAC && !rx_side.dv && rx_side.data == 4'h1;
	endproperty
	a_lpi: assert property (p_lpi) else $error("low power idle flag");
	property p_hold;
		$changed(rx_side) || $changed(tx_side) |-> st;
	endproperty
	a_hold: assert property (p_hold) else $error("sample moved off strobe");
	c_abort: cover property (st && tx_side.abort);
	c_lpi: cover property (st && rx_side.lpi);
	c_iso: cover property (phy && virtual_port_isolate);
endmodule : pim_port_input_mux_sva

bind pim_port_input_mux pim_port_input_mux_sva u_sva (
	.core_clk            (core_clk),
	.sys_rst             (sys_rst),
	.mode                (mode),
	.virtual_port_isolate(virtual_port_isolate),
	.port_in_pulldown_en (port_in_pulldown_en),
	.port_in_buffer_en   (port_in_buffer_en),
	.rx_side             (rx_side),
	.tx_side             (tx_side),
	.sample_strobe       (sample_strobe)
);

// file: tb/pim_far_end.sv
`timescale 1ns/10ps
module pim_far_end (
	input wire logic   ref_clk,
	output logic [3:0] data,
	output logic       valid,
	output logic       error
);
	initial {data, valid, error} = 6'h00;
	// one symbol per edge; idle is zero, the pull-down level
	task automatic put(input logic [3:0] d, input logic v, input logic e);
		@(posedge ref_clk);
		data  <= d;
		valid <= v;
		error <= e;
	endtask : put
endmodule : pim_far_end

// file: tb/pim_port_input_mux_tb.sv
`timescale 1ns/10ps
`define CHK(a, b) begin checks++; if ((a) !== (b)) begin mismatches++; $display("ERROR %0t: got %h want %h", $time, a, b); end end
module pim_port_input_mux_tb
	import pim_pkg::*;
;
	logic       core_clk = 1'b0;
	logic       sys_rst  = 1'b1;
	logic       lclk     = 1'b0;
	logic       iso      = 1'b0;
	pim_mode_e  mode     = PIM_MII_MAC;
	logic [3:0] pd;
	logic       v;
	logic       e;
	logic [2:0] pull;
	logic [2:0] buf_en;
	pim_rx_s    rx;
	pim_rx_s    rx1;
	pim_tx_s    tx;
	pim_tx_s    tx1;
	logic       stb;
	logic       ovf;
	int         mismatches = 0;
	int         checks     = 0;
	int         cyc        = 0;
	int         n;
	always #12.5 core_clk = ~core_clk;
	// free-running like a receive clock, phase unrelated to the core
	initial
	begin
		#3.1;
		forever #7.5 lclk = ~lclk;
	end
	pim_port_input_mux DUT (.core_clk(core_clk), .sys_rst(sys_rst), .port_in_ref_clock(lclk), .mode(mode),
		.virtual_port_isolate(iso), .port_in_data_bus(pd), .port_in_valid(v), .port_in_error(e),
		.port_in_pulldown_en(pull), .port_in_buffer_en(buf_en), .rx_side(rx), .tx_side(tx),
		.sample_strobe(stb), .overflow_pulse(ovf));
	pim_far_end fe (.ref_clk(lclk), .data(pd), .valid(v), .error(e));
	task automatic stop_test;
		$display("mismatches %0d checks %0d", mismatches, checks);
		if (mismatches == 0 && checks > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask : stop_test
	always @(posedge core_clk)
	begin
		cyc++;
		if (cyc == 5000)
		begin
			mismatches++;
			stop_test();
		end
	end
	// one symbol then idle; counts strobes, keeps the first sample
	task automatic xfer(input pim_mode_e m, input logic i, input logic [3:0] d, input logic vv, input logic ee);
		@(posedge core_clk);
		mode <= m;
		iso  <= i;
		repeat (4) @(posedge core_clk);
		fe.put(d, vv, ee);
		fe.put(4'h0, 1'b0, 1'b0);
		n = 0;
		repeat (60)
		begin
			@(posedge core_clk);
			#1;
			if (stb === 1'b1)
			begin
				if (n == 0)
					{rx1, tx1} = {rx, tx};
				n++;
			end
		end
	endtask : xfer
	task automatic t_pins;
		for (int i = 0; i < 5; i++)
			for (int j = 0; j < 2; j++)
			begin
				@(posedge core_clk);
				mode <= pim_mode_e'(i);
				iso  <= j[0];
				repeat (2) @(posedge core_clk);
				#1;
				`CHK({pull, buf_en}, i == 4 ? 6'h38 : (j == 1 && (i == 1 || i == 3)) ? 6'h00 : 6'h3f)
			end
	endtask : t_pins
	task automatic t_mii_phy;
		xfer(PIM_MII_PHY, 1'b0, 4'h5, 1'b1, 1'b0);
		`CHK(n, 2)
		`CHK(tx1, pim_tx_s'{4'h5, 1'b1, 1'b0})
		`CHK(tx, pim_tx_s'{4'h0, 1'b0, 1'b0})
		xfer(PIM_MII_PHY, 1'b0, 4'ha, 1'b1, 1'b1);
		`CHK(tx1, pim_tx_s'{4'ha, 1'b1, 1'b1})
		xfer(PIM_MII_PHY, 1'b0, 4'h3, 1'b0, 1'b1);
		`CHK(tx1, pim_tx_s'{4'h0, 1'b0, 1'b0})
	endtask : t_mii_phy
	task automatic t_mii_mac;
		xfer(PIM_MII_MAC, 1'b0, 4'h9, 1'b1, 1'b1);
		`CHK({rx1.data, rx1.dv, rx1.er, rx1.lpi}, 7'h4e)
		xfer(PIM_MII_MAC, 1'b0, 4'h1, 1'b0, 1'b1);
		`CHK({rx1.data, rx1.dv, rx1.er, rx1.lpi}, 7'h09)
	endtask : t_mii_mac
	task automatic t_rmii;
		xfer(PIM_RMII_MAC, 1'b0, 4'hf, 1'b1, 1'b1);
		`CHK({rx1.data, rx1.crs_dv, rx1.er}, 6'h0f)
		xfer(PIM_RMII_PHY, 1'b0, 4'hf, 1'b1, 1'b1);
		`CHK(tx1, pim_tx_s'{4'h3, 1'b1, 1'b0})
	endtask : t_rmii
	task automatic t_gated;
		xfer(PIM_INT_PHY, 1'b0, 4'hf, 1'b1, 1'b1);
		`CHK(n, 0)
		xfer(PIM_MII_PHY, 1'b1, 4'hf, 1'b1, 1'b1);
		`CHK(n, 0)
		xfer(PIM_RMII_PHY, 1'b1, 4'hf, 1'b1, 1'b0);
		`CHK(n, 0)
	endtask : t_gated
	// link rate above core drain rate: a long burst must overflow and say so
	task automatic t_burst;
		int nov;
		nov = 0;
		n   = 0;
		@(posedge core_clk);
		mode <= PIM_MII_MAC;
		iso  <= 1'b0;
		repeat (4) @(posedge core_clk);
		fork
			begin
				for (int k = 0; k < 40; k++)
					fe.put(4'(k), 1'b1, 1'b0);
				fe.put(4'h0, 1'b0, 1'b0);
			end
			repeat (120)
			begin
				@(posedge core_clk);
				#1;
				if (stb === 1'b1)
					n++;
				if (ovf === 1'b1)
					nov++;
			end
		join
		`CHK(nov > 0, 1'b1)
		`CHK(n < 41, 1'b1)
		`CHK(n > 7, 1'b1)
	endtask : t_burst
	initial
	begin
		repeat (20) @(posedge core_clk);
		sys_rst <= 1'b0;
		repeat (20) @(posedge core_clk);
		t_pins();
		t_mii_phy();
		t_mii_mac();
		t_rmii();
		t_gated();
		t_burst();
		stop_test();
	end
endmodule : pim_port_input_mux_tb
